// ===== shared/fmh_pkg.sv
// Package of fault monitor and hour statistics constants
package fmh_pkg;

    // ****************************************
    // Register map, byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CB_LO = 8'h08;
    localparam logic [7:0] ADDR_CB_HI = 8'h0C;
    localparam logic [7:0] ADDR_TRAIL = 8'h10;
    localparam logic [7:0] ADDR_DIAG_REQ = 8'h14;
    localparam logic [7:0] ADDR_DIAG_SNAP = 8'h18;
    localparam logic [7:0] ADDR_TEMP = 8'h1C;
    localparam logic [7:0] ADDR_CLS01 = 8'h20;
    localparam logic [7:0] ADDR_CLS23 = 8'h24;
    localparam logic [7:0] ADDR_CLS45 = 8'h28;
    localparam logic [7:0] ADDR_HOURS = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h34;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h38;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int FLT_CMD = 0;
    localparam int FLT_FB = 1;
    localparam int FLT_SHORT = 2;
    localparam int FLT_OPEN = 3;
    localparam int FLT_TRAIL = 4;
    localparam int NFLT = 5;
    localparam int CTRL_TRAIL_POS = 8;
    localparam int SNAP_CH_POS = 8;
    localparam int IRQ_SUPPLY = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_SAVE = 2;
    localparam int NIRQ = 3;

    // ****************************************
    // Limits, class bounds and reset values
    // ****************************************
    localparam logic [15:0] SUPPLY_MIN_MV = 16'h1770;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam int NCLS = 6;
    localparam logic signed [15:0] TCLS_B1 = 16'sh0000;
    localparam logic signed [15:0] TCLS_B2 = 16'sh0014;
    localparam logic signed [15:0] TCLS_B3 = 16'sh0028;
    localparam logic signed [15:0] TCLS_B4 = 16'sh003C;
    localparam logic signed [15:0] TCLS_B5 = 16'sh0050;
    localparam logic [15:0] CB_LO_RST = 16'h0000;
    localparam logic [15:0] CB_HI_RST = 16'hFFFF;
    localparam logic [15:0] TRAIL_RST = 16'h0100;
    localparam logic signed [15:0] TMIN_RST = 16'sh7FFF;
    localparam logic signed [15:0] TMAX_RST = 16'sh8000;
    localparam logic [3:0] NVM_WORDS = 4'h9;
    localparam logic [3:0] NVA_TMIN = 4'h0;
    localparam logic [3:0] NVA_TMAX = 4'h1;
    localparam logic [3:0] NVA_HOURS = 4'h8;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint unsigned CLK_HZ = 64'd20000000;
    localparam longint unsigned HOUR_S = 64'd3600;
    localparam longint unsigned HOUR_CYC = HOUR_S * CLK_HZ;
    localparam longint unsigned BLINK_MS = 64'd250;
    localparam longint unsigned BLINK_CYC = BLINK_MS * CLK_HZ / 64'd1000;

endpackage

// ===== rtl/fmh_monitor.sv
// Fault monitor with hourly temperature and operating hour statistics
//
// Functional notes
// - Supply below 6 V gives supply error, ready otherwise.
// - Command cable break only when checking enabled and outside limits.
// - Feedback cable break only when checking enabled and outside limits.
// - Solenoid output short circuit flags a channel fault.
// - Solenoid output open circuit flags a channel fault.
// - Control deviation magnitude above trailing window flags fault.
// - Latched fault clears only when cause gone and channel re-enabled.
// - Each channel shows error while any of its faults is active.
// - Red LED flashes while any fault is active.
// - Temperature statistics written to non-volatile memory every hour.
// - Nothing is stored before the first full hour of power-on.
// - Lowest temperature ever seen is tracked continuously.
// - Highest temperature ever seen is tracked continuously.
// - Hourly temperature sample bumps one of six class counters.
// - All class counters freeze once any reaches 65535.
// - Operating hours counter increments hourly and is saved.
// - Operating hours counter holds at 65535.
// - Diagnostics request captures a one-time fault snapshot.
`timescale 1ns/1ps
module fmh_monitor
    import fmh_pkg::*;
#(
    parameter int NCH = 2,
    parameter int VW = 16,
    parameter longint unsigned HOUR_CYCLES = HOUR_CYC,
    parameter longint unsigned BLINK_CYCLES = BLINK_CYC
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] supply_mv,
    input wire logic signed [15:0] temp_c,
    input wire logic [NCH*VW-1:0] cmd_val,
    input wire logic [NCH*VW-1:0] fb_val,
    input wire logic [NCH*VW-1:0] ctrl_dev,
    input wire logic [NCH-1:0] short_det,
    input wire logic [NCH-1:0] open_det,
    input wire logic [NCH-1:0] chan_en,
    output logic [NCH-1:0] chan_err,
    output logic supply_err,
    output logic led_red,
    output logic nvm_we,
    output logic [3:0] nvm_addr,
    output logic [15:0] nvm_wdata,
    output logic irq
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NCH-1:0] en_s1;
        logic [NCH-1:0] en_s2;
        logic [NCH-1:0] en_d;
        logic [NCH-1:0][NFLT-1:0] flt;
        logic supply_err;
        logic [NCH-1:0] chan_err;
        logic [NCH-1:0] cb_en;
        logic [NCH-1:0] trail_en;
        logic [VW-1:0] cb_lo;
        logic [VW-1:0] cb_hi;
        logic [VW-1:0] trail_win;
        logic [31:0] snap;
        logic signed [15:0] tmin;
        logic signed [15:0] tmax;
        logic [NCLS-1:0][15:0] cls;
        logic [15:0] hours;
        logic [39:0] hour_cnt;
        logic [3:0] save_cnt;
        logic [31:0] blink_cnt;
        logic led;
        logic [NIRQ-1:0] irq_stat;
        logic [NIRQ-1:0] irq_en;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic nvm_we;
        logic [3:0] nvm_addr;
        logic [15:0] nvm_wdata;
    } fmh_state_s;

    fmh_state_s r;
    fmh_state_s n;

    localparam logic [39:0] HOUR_LAST = 40'(HOUR_CYCLES - 64'd1);
    localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 64'd1);

    logic [NCH-1:0][NFLT-1:0] cause;
    logic [NCH-1:0][NFLT-1:0] flt_nxt;
    logic [NCH-1:0] en_rise;
    logic setup;
    logic access;
    logic wr;
    logic hour_tick;
    logic cls_sat;
    logic [2:0] cls_idx;
    logic [3:0] save_idx;
    logic [NIRQ-1:0] irq_ev;
    logic [NIRQ-1:0] irq_clr;
    logic any_fault;

    function automatic logic [2:0] cls_of(input logic signed [15:0] t);
        if (t < TCLS_B1)
            return 3'h0;
        if (t < TCLS_B2)
            return 3'h1;
        if (t < TCLS_B3)
            return 3'h2;
        if (t < TCLS_B4)
            return 3'h3;
        if (t < TCLS_B5)
            return 3'h4;
        return 3'h5;
    endfunction

    // ****************************************
    // Per-channel fault causes
    // ****************************************
    generate
        for (genvar ch = 0; ch < NCH; ch++)
        begin : g_ch
            logic [VW-1:0] cmd;
            logic [VW-1:0] fb;
            logic [VW-1:0] dev;
            logic [VW-1:0] mag;
            assign cmd = cmd_val[ch*VW +: VW];
            assign fb = fb_val[ch*VW +: VW];
            assign dev = ctrl_dev[ch*VW +: VW];
            assign mag = dev[VW-1] ? VW'(~dev + 1'b1) : dev;
            assign cause[ch][FLT_CMD] = r.cb_en[ch]
                & ((cmd < r.cb_lo) | (cmd > r.cb_hi));
            assign cause[ch][FLT_FB] = r.cb_en[ch]
                & ((fb < r.cb_lo) | (fb > r.cb_hi));
            assign cause[ch][FLT_SHORT] = short_det[ch];
            assign cause[ch][FLT_OPEN] = open_det[ch];
            assign cause[ch][FLT_TRAIL] = r.trail_en[ch]
                & (mag > r.trail_win);
            // A new cause always wins over the re-enable clear
            assign en_rise[ch] = r.en_s2[ch] & ~r.en_d[ch];
            assign flt_nxt[ch] = (r.flt[ch] & ~{NFLT{en_rise[ch]}})
                | cause[ch];
        end
    endgenerate

    assign setup = psel & ~penable;
    assign access = psel & penable & r.pready;
    assign wr = access & pwrite;
    assign hour_tick = (r.hour_cnt == HOUR_LAST);
    assign cls_idx = cls_of(temp_c);
    assign save_idx = NVM_WORDS - r.save_cnt;
    assign any_fault = r.supply_err | (|r.chan_err);
    assign irq_clr = (wr && paddr == ADDR_IRQ_CLR) ? pwdata[NIRQ-1:0]
        : '0;

    always_comb
    begin
        cls_sat = 1'b0;
        for (int i = 0; i < NCLS; i++)
        begin
            if (r.cls[i] == CNT_MAX)
                cls_sat = 1'b1;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        n = r;
        irq_ev = '0;

        // Channel enables are pins: two flops before any use
        n.en_s1 = chan_en;
        n.en_s2 = r.en_s1;
        n.en_d = r.en_s2;

        n.flt = flt_nxt;
        for (int ch = 0; ch < NCH; ch++)
        begin
            n.chan_err[ch] = |flt_nxt[ch];
        end
        n.supply_err = (supply_mv < SUPPLY_MIN_MV);
        irq_ev[IRQ_SUPPLY] = n.supply_err & ~r.supply_err;
        irq_ev[IRQ_FAULT] = |(flt_nxt & ~r.flt);

        // Blinking rather than steady so the fault reads at a glance
        if (any_fault)
        begin
            if (r.blink_cnt == BLINK_LAST)
            begin
                n.blink_cnt = '0;
                n.led = ~r.led;
            end
            else
            begin
                n.blink_cnt = r.blink_cnt + 32'h1;
            end
        end
        else
        begin
            n.blink_cnt = '0;
            n.led = 1'b0;
        end

        if (temp_c < r.tmin)
            n.tmin = temp_c;
        if (temp_c > r.tmax)
            n.tmax = temp_c;

        // Counter starts from zero at every power-on, so a short
        // session never reaches a tick and nothing is stored
        n.hour_cnt = hour_tick ? '0 : r.hour_cnt + 40'h1;
        if (hour_tick)
        begin
            if (!cls_sat)
                n.cls[cls_idx] = r.cls[cls_idx] + 16'h1;
            if (r.hours != CNT_MAX)
                n.hours = r.hours + 16'h1;
            n.save_cnt = NVM_WORDS;
        end

        n.nvm_we = 1'b0;
        n.nvm_addr = r.nvm_addr;
        n.nvm_wdata = r.nvm_wdata;
        if (r.save_cnt != 4'h0)
        begin
            n.nvm_we = 1'b1;
            n.nvm_addr = save_idx;
            unique case (save_idx)
                NVA_TMIN: n.nvm_wdata = r.tmin;
                NVA_TMAX: n.nvm_wdata = r.tmax;
                NVA_HOURS: n.nvm_wdata = r.hours;
                default: n.nvm_wdata = r.cls[save_idx - 4'h2];
            endcase
            if (!hour_tick)
                n.save_cnt = r.save_cnt - 4'h1;
            if (r.save_cnt == 4'h1)
                irq_ev[IRQ_SAVE] = 1'b1;
        end

        // ****************************************
        // APB slave: answer one cycle after setup
        // ****************************************
        n.pready = setup;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (setup)
        begin
            unique case (paddr)
                ADDR_STATUS:
                begin
                    n.prdata[0] = r.supply_err;
                    n.prdata[SNAP_CH_POS +: NCH] = r.chan_err;
                end
                ADDR_CTRL:
                begin
                    n.prdata[NCH-1:0] = r.cb_en;
                    n.prdata[CTRL_TRAIL_POS +: NCH] = r.trail_en;
                end
                ADDR_CB_LO: n.prdata[VW-1:0] = r.cb_lo;
                ADDR_CB_HI: n.prdata[VW-1:0] = r.cb_hi;
                ADDR_TRAIL: n.prdata[VW-1:0] = r.trail_win;
                ADDR_DIAG_REQ: n.prdata = '0;
                ADDR_DIAG_SNAP: n.prdata = r.snap;
                ADDR_TEMP: n.prdata = {r.tmax, r.tmin};
                ADDR_CLS01: n.prdata = {r.cls[1], r.cls[0]};
                ADDR_CLS23: n.prdata = {r.cls[3], r.cls[2]};
                ADDR_CLS45: n.prdata = {r.cls[5], r.cls[4]};
                ADDR_HOURS: n.prdata[15:0] = r.hours;
                ADDR_IRQ_STAT: n.prdata[NIRQ-1:0] = r.irq_stat;
                ADDR_IRQ_CLR: n.prdata = '0;
                ADDR_IRQ_EN: n.prdata[NIRQ-1:0] = r.irq_en;
                default: n.pslverr = 1'b1;
            endcase
        end

        if (wr)
        begin
            unique case (paddr)
                ADDR_CTRL:
                begin
                    n.cb_en = pwdata[NCH-1:0];
                    n.trail_en = pwdata[CTRL_TRAIL_POS +: NCH];
                end
                ADDR_CB_LO: n.cb_lo = pwdata[VW-1:0];
                ADDR_CB_HI: n.cb_hi = pwdata[VW-1:0];
                ADDR_TRAIL: n.trail_win = pwdata[VW-1:0];
                ADDR_DIAG_REQ:
                begin
                    // Snapshot only; it is not refreshed afterwards
                    n.snap = '0;
                    n.snap[0] = r.supply_err;
                    n.snap[SNAP_CH_POS +: NCH*NFLT] = r.flt;
                end
                ADDR_IRQ_EN: n.irq_en = pwdata[NIRQ-1:0];
                default:
                begin
                end
            endcase
        end

        // Set wins over a clear in the same cycle
        n.irq_stat = (r.irq_stat & ~irq_clr) | irq_ev;
        n.irq = |(r.irq_stat & r.irq_en);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            r <= '0;
            r.cb_hi <= VW'(CB_HI_RST);
            r.cb_lo <= VW'(CB_LO_RST);
            r.trail_win <= VW'(TRAIL_RST);
            r.tmin <= TMIN_RST;
            r.tmax <= TMAX_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign chan_err = r.chan_err;
    assign supply_err = r.supply_err;
    assign led_red = r.led;
    assign nvm_we = r.nvm_we;
    assign nvm_addr = r.nvm_addr;
    assign nvm_wdata = r.nvm_wdata;
    assign irq = r.irq;

endmodule

// ===== verification/fmh_monitor_asserts.sv
// Checker of fault flags, blink and hourly save burst
`timescale 1ns/1ps
module fmh_monitor_chk
    import fmh_pkg::*;
#(
    parameter int NCH = 2,
    parameter longint unsigned HOUR_CYCLES = HOUR_CYC,
    parameter longint unsigned BLINK_CYCLES = BLINK_CYC
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [15:0] supply_mv,
    input wire logic [NCH-1:0] short_det,
    input wire logic [NCH-1:0] open_det,
    input wire logic [NCH-1:0] chan_en,
    input wire logic [NCH-1:0] chan_err,
    input wire logic supply_err,
    input wire logic led_red,
    input wire logic nvm_we,
    input wire logic [3:0] nvm_addr
);
    // ****************************************
    // Helper counters
    // ****************************************
    logic [2:0] low_r;
    logic [7:0] hold_r;
    logic [3:0] burst_r;
    longint unsigned age_r;
    logic flt;

    assign flt = (chan_err != '0) || supply_err;

    // Low count saturates so a long disable cannot wrap to zero
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            low_r <= 3'h0;
            hold_r <= 8'h00;
            burst_r <= 4'h0;
            age_r <= 0;
        end
        else
        begin
            low_r <= chan_en[0] ? 3'h0 : low_r + {2'h0, low_r != 3'h7};
            hold_r <= (flt && $stable(led_red)) ? hold_r + 8'h01 : 8'h00;
            // Burst length counted here, not spelled out as a repetition
            burst_r <= nvm_we ? burst_r + 4'h1 : 4'h0;
            age_r <= age_r + (age_r < HOUR_CYCLES);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    supply_flag_a: assert property (
        !$past(srst) |-> supply_err == ($past(supply_mv) < SUPPLY_MIN_MV))
        else $error("supply flag wrong");
    short_flag_a: assert property (
        short_det != '0 |=> (chan_err & $past(short_det)) == $past(short_det))
        else $error("short not flagged");
    open_flag_a: assert property (
        open_det != '0 |=> (chan_err & $past(open_det)) == $past(open_det))
        else $error("open not flagged");
    fault_hold_a: assert property (
        chan_err[0] && low_r >= 3'h4 |=> chan_err[0])
        else $error("fault cleared without re-enable");
    led_quiet_a: assert property (
        (!flt) [*3] |-> !led_red)
        else $error("led lit without fault");
    led_blink_a: assert property (
        hold_r <= BLINK_CYCLES + 3)
        else $error("led not flashing");
    first_hour_a: assert property (
        nvm_we |-> age_r >= HOUR_CYCLES)
        else $error("save before first hour");
    save_burst_a: assert property (
        $fell(nvm_we) |-> burst_r == NVM_WORDS)
        else $error("save burst length wrong");
    save_long_a: assert property (
        nvm_we |-> burst_r < NVM_WORDS)
        else $error("save burst too long");
    save_start_a: assert property (
        $rose(nvm_we) |-> nvm_addr == NVA_TMIN)
        else $error("save burst start wrong");
    save_order_a: assert property (
        nvm_we && $past(nvm_we) |-> nvm_addr == $past(nvm_addr) + 4'h1)
        else $error("save order wrong");

    cover property ($rose(chan_err[0]));
    cover property ($rose(nvm_we));
    cover property ($rose(led_red));
endmodule

bind fmh_monitor fmh_monitor_chk #(.NCH(NCH), .HOUR_CYCLES(HOUR_CYCLES),
    .BLINK_CYCLES(BLINK_CYCLES)) u_fmh_monitor_chk (.clock, .srst,
    .supply_mv, .short_det, .open_det, .chan_en, .chan_err, .supply_err,
    .led_red, .nvm_we, .nvm_addr);

// ===== verification/fmh_host.sv
// Host tool model: APB master reading diagnostics and statistics
`timescale 1ns/1ps
module fmh_host
    import fmh_pkg::*;
(
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
    end

    // Request held until the rising edge that sees pready; answer taken there
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask

    task automatic snap(output logic [31:0] q);
        logic e;
        xfer(1'b1, ADDR_DIAG_REQ, 32'h1, q, e);
        xfer(1'b0, ADDR_DIAG_SNAP, 32'h0, q, e);
    endtask
endmodule

// ===== verification/test_fmh_monitor.sv
// Self-checking bench of the fault monitor with hourly statistics
`timescale 1ns/1ps
module test_fmh_monitor
    import fmh_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic supply_err, led_red, nvm_we, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, seed = 32'h5D5F;
    logic [15:0] supply_mv = 16'h1770, nvm_wdata, hours_e = 16'h0;
    logic signed [15:0] temp_c = 16'h19, tmin_e = 16'h19, tmax_e = 16'h19;
    logic [31:0] cmd_val = 32'h00640064, fb_val = 32'h00C800C8;
    logic [31:0] ctrl_dev = 32'h00100010;
    logic [1:0] short_det = 2'h0, open_det = 2'h0, chan_en = 2'h3, chan_err;
    logic [3:0] nvm_addr;
    logic [15:0] cls_e [6] = '{default: 16'h0};
    logic [15:0] mem [9];
    logic signed [15:0] tc [6] = '{16'hFFFF, 16'h0, 16'h27, 16'h28,
        16'h4F, 16'h50};
    int bad_count = 0, tests_run = 0, cycles = 0, bursts = 0;

    always #25 clock = ~clock;

    fmh_monitor #(.HOUR_CYCLES(200), .BLINK_CYCLES(4)) u_fmh_monitor (.clock,
        .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .supply_mv, .temp_c, .cmd_val, .fb_val, .ctrl_dev,
        .short_det, .open_det, .chan_en, .chan_err, .supply_err, .led_red,
        .nvm_we, .nvm_addr, .nvm_wdata, .irq);
    fmh_host u_fmh_host (.clock, .prdata, .pready, .pslverr, .psel,
        .penable, .pwrite, .paddr, .pwdata);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int cls_of(input logic signed [15:0] t);
        if (t < 0)
            return 0;
        return (t >= 80) ? 5 : t / 20 + 1;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        u_fmh_host.xfer(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_fmh_host.xfer(1'b1, a, d, q, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic set_temp(input logic signed [15:0] t);
        @(posedge clock);
        temp_c <= t;
        if (t < tmin_e)
            tmin_e = t;
        if (t > tmax_e)
            tmax_e = t;
    endtask

    task automatic cause(input int k, input int ch, input logic on);
        case (k)
            0: cmd_val[ch*16 +: 16] <= on ? 16'h63 : 16'h64;
            1: fb_val[ch*16 +: 16] <= on ? 16'hC9 : 16'hC8;
            2: short_det[ch] <= on;
            3: open_det[ch] <= on;
            default: ctrl_dev[ch*16 +: 16] <= on ? 16'hFFEF : 16'h10;
        endcase
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Model of the hourly save, checked as the last word goes out
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            print_verdict();
        end
        if (nvm_we)
            mem[nvm_addr] = nvm_wdata;
        if (nvm_we && nvm_addr == NVA_HOURS)
        begin
            bursts++;
            hours_e++;
            cls_e[cls_of(temp_c)]++;
            check({mem[NVA_TMAX], mem[NVA_TMIN]}, {tmax_e, tmin_e});
            for (int i = 0; i < 6; i++)
                check({16'h0, mem[i+2]}, {16'h0, cls_e[i]});
            check({16'h0, nvm_wdata}, {16'h0, hours_e});
        end
    end

    initial
    begin
        int ch, b;
        tick(2);
        srst <= 1'b0;
        rd(ADDR_CB_HI, 32'hFFFF);
        rd(ADDR_TRAIL, 32'h0100);
        rd(ADDR_TEMP, 32'h00190019);
        rd(8'h3C, 32'h0);
        check({31'h0, e}, 32'h1);
        wr(ADDR_IRQ_EN, 32'h7);
        supply_mv <= 16'h176F;
        tick(3);
        rd(ADDR_STATUS, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd(ADDR_IRQ_STAT, 32'h1);
        supply_mv <= 16'h1770;
        wr(ADDR_IRQ_CLR, 32'h1);
        tick(2);
        check({31'h0, irq}, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        for (int i = 0; i < 20; i++)
        begin
            seed = lfsr(seed);
            set_temp({{8{seed[7]}}, seed[7:0]});
        end
        tick(2);
        rd(ADDR_TEMP, {tmax_e, tmin_e});
        check(32'(bursts), 32'h0);
        wr(ADDR_CB_LO, 32'h64);
        wr(ADDR_CB_HI, 32'hC8);
        wr(ADDR_TRAIL, 32'h10);
        cmd_val <= 32'h0;
        tick(3);
        check({30'h0, chan_err}, 32'h0);
        cmd_val <= 32'h00640064;
        wr(ADDR_CTRL, 32'h0303);
        tick(2);
        check({30'h0, chan_err}, 32'h0);
        for (int k = 0; k < 5; k++)
        begin
            ch = k % 2;
            cause(k, ch, 1'b1);
            tick(2);
            check({30'h0, chan_err}, 32'h1 << ch);
            u_fmh_host.snap(q);
            cause(k, ch, 1'b0);
            tick(2);
            check(q, 32'h1 << (8 + ch * 5 + k));
            check({30'h0, chan_err}, 32'h1 << ch);
            chan_en[ch] <= 1'b0;
            tick(4);
            chan_en[ch] <= 1'b1;
            tick(6);
            check({30'h0, chan_err}, 32'h0);
            rd(ADDR_DIAG_SNAP, q);
        end
        for (int i = 0; i < 7; i++)
        begin
            b = bursts;
            while (bursts == b)
                tick(1);
            if (i < 6)
                set_temp(tc[i]);
        end
        print_verdict();
    end
endmodule
